// ===== hdl/synth_cfg_pkg.sv
// holds register offsets, field layouts, reset values and timing constants
// assumes a 125 MHz core clock and a 32-bit word-aligned register bus
package synth_cfg_pkg;

	localparam int          CLK_PERIOD_PS = 8000;
	localparam int          BUS_W         = 32;
	localparam int          ADDR_W        = 4;

	localparam logic [3:0]  OFS_CONFIG    = 4'h0;
	localparam logic [3:0]  OFS_FRAC_NUM  = 4'h4;
	localparam logic [3:0]  OFS_FRAC_DEN  = 4'h8;
	localparam logic [3:0]  OFS_STATUS    = 4'hc;

	localparam int          POS_POLARITY  = 0;
	localparam int          POS_DOUBLER   = 1;
	localparam int          POS_WIDE      = 2;
	localparam int          POS_HIGH_Z    = 3;
	localparam int          POS_ORDER     = 4;
	localparam int          POS_DITHER    = 8;
	localparam int          POS_WINDOW    = 12;
	localparam int          POS_TEST_SEL  = 16;
	localparam int          ORDER_W       = 3;
	localparam int          DITHER_W      = 2;
	localparam int          WIN_W         = 3;
	localparam int          SEL_W         = 4;

	localparam logic [31:0] CONFIG_RESET  = 32'h0000_0304;
	localparam logic [31:0] CONFIG_MASK   = 32'h000f_737f;

	localparam int          FRAC_W        = 22;
	localparam logic [21:0] NARROW_MASK   = 22'h0003ff;

	localparam logic [2:0]  ORDER_INTEGER = 3'h0;
	localparam logic [2:0]  ORDER_FIRST   = 3'h1;
	localparam logic [2:0]  ORDER_MAX     = 3'h4;
	localparam logic [1:0]  DITHER_OFF    = 2'h3;

	localparam logic [2:0]  WIN_MAX_CODE  = 3'h5;
	localparam int          WIN_BASE_PS   = 3500;
	localparam int          WIN_STEP_PS   = 2000;

	localparam int          LOCK_CYCLES   = 5;
	localparam int          GOOD_W        = 3;

	localparam int          ST_LOCK       = 0;
	localparam int          ST_REF_LOST   = 1;
	localparam int          ST_ORDER_BAD  = 2;
	localparam int          ST_WIN_BAD    = 3;
	localparam int          ST_GOOD       = 4;

	localparam logic [3:0]  TP_HIGH_Z     = 4'h0;
	localparam logic [3:0]  TP_HIGH       = 4'h1;
	localparam logic [3:0]  TP_LOW        = 4'h2;
	localparam logic [3:0]  TP_LOCK       = 4'h3;
	localparam logic [3:0]  TP_LOCK_INV   = 4'h4;
	localparam logic [3:0]  TP_LOCK_OD    = 4'h5;
	localparam logic [3:0]  TP_ALOCK_OD   = 4'h6;
	localparam logic [3:0]  TP_ALOCK      = 4'h7;
	localparam logic [3:0]  TP_FB         = 4'h8;
	localparam logic [3:0]  TP_FB_HALF    = 4'h9;
	localparam logic [3:0]  TP_REF        = 4'ha;
	localparam logic [3:0]  TP_REF_HALF   = 4'hb;
	localparam logic [3:0]  TP_PFD_UP     = 4'hc;
	localparam logic [3:0]  TP_PFD_DOWN   = 4'hd;

	// a longest time: rounds down, never below one cycle
	function automatic int win_cycles(input logic [2:0] code);
		int ps;
		int c;
		ps = WIN_BASE_PS + WIN_STEP_PS * int'(code);
		c = ps / CLK_PERIOD_PS;
		return (c < 1) ? 1 : c;
	endfunction : win_cycles

endpackage : synth_cfg_pkg

// ===== hdl/lock_if.sv
// holds the link between the control logic and the lock detector
// assumes both ends run on the core clock
`timescale 1ns/10ps
interface lock_if #(
	parameter int CNT_W = 8
);
	logic                          ref_edge;
	logic                          fb_edge;
	logic [CNT_W-1:0]              window;
	logic                          locked;
	logic                          ref_lost;
	logic [synth_cfg_pkg::GOOD_W-1:0] good_cnt;

	modport ctrl (
		output ref_edge,
		output fb_edge,
		output window,
		input  locked,
		input  ref_lost,
		input  good_cnt
	);

	modport det (
		input  ref_edge,
		input  fb_edge,
		input  window,
		output locked,
		output ref_lost,
		output good_cnt
	);
endinterface : lock_if

// ===== hdl/lock_detect.sv
// holds the digital lock detector that judges each phase detector cycle
// assumes edge pulses of one core clock cycle, synchronous to the clock
`timescale 1ns/10ps
module lock_detect #(
	parameter int CNT_W   = 8,
	parameter int LOCK_N  = synth_cfg_pkg::LOCK_CYCLES,
	parameter int TIMEOUT = 1024
) (
	// clock, reset and enable
	input  wire logic core_clk_in,
	input  wire logic sys_rst_in,
	input  wire logic ce_in,
	// detector side of the link
	lock_if.det       lk
);
	typedef enum logic [1:0] {IDLE, WAIT_FB, WAIT_REF} det_state_t;
	localparam int QW = $clog2(TIMEOUT + 1);
	localparam logic [synth_cfg_pkg::GOOD_W-1:0] LAST_GOOD =
		synth_cfg_pkg::GOOD_W'(LOCK_N - 1);
	localparam logic [QW-1:0] QUIET_END = QW'(TIMEOUT - 1);

	det_state_t                       state_q, state_d;
	logic [CNT_W-1:0]                 cnt_q, cnt_d;
	logic [QW-1:0]                    quiet_q;
	logic [synth_cfg_pkg::GOOD_W-1:0] good_q;
	logic                             locked_q, lost_q;
	logic                             good_ev, bad_ev;

	wire logic [CNT_W-1:0] offset   = cnt_q + CNT_W'(1);
	wire logic             in_win   = offset < lk.window;
	wire logic             expire   = ~in_win;
	// an edge on the last quiet cycle still proves the reference alive
	wire logic             lost_ev  = quiet_q == QUIET_END && !lk.ref_edge;

	// one verdict per cycle of the phase detector
	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q + CNT_W'(1);
		good_ev = 1'b0;
		bad_ev  = 1'b0;
		unique case (state_q)
			IDLE: begin
				cnt_d = '0;
				if (lk.ref_edge && lk.fb_edge) begin
					good_ev = 1'b1;
				end else if (lk.ref_edge) begin
					state_d = WAIT_FB;
				end else if (lk.fb_edge) begin
					state_d = WAIT_REF;
				end
			end
			WAIT_FB: begin
				if (lk.fb_edge) begin
					good_ev = in_win;
					bad_ev  = ~in_win;
					state_d = IDLE;
				end else if (lk.ref_edge || expire) begin
					bad_ev  = 1'b1;
					state_d = lk.ref_edge ? WAIT_FB : IDLE;
					cnt_d   = '0;
				end
			end
			WAIT_REF: begin
				if (lk.ref_edge) begin
					good_ev = in_win;
					bad_ev  = ~in_win;
					state_d = IDLE;
				end else if (lk.fb_edge || expire) begin
					bad_ev  = 1'b1;
					state_d = lk.fb_edge ? WAIT_REF : IDLE;
					cnt_d   = '0;
				end
			end
		endcase
	end

	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			state_q <= IDLE;
			cnt_q   <= '0;
		end else if (ce_in) begin
			state_q <= lost_ev ? IDLE : state_d;
			cnt_q   <= cnt_d;
		end
	end

	// a stopped reference must not leave a stale lock behind
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			quiet_q <= '0;
			lost_q  <= 1'b0;
		end else if (ce_in) begin
			if (lk.ref_edge) begin
				quiet_q <= '0;
				lost_q  <= 1'b0;
			end else if (lost_ev) begin
				lost_q  <= 1'b1;
			end else begin
				quiet_q <= quiet_q + QW'(1);
			end
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			good_q   <= '0;
			locked_q <= 1'b0;
		end else if (ce_in) begin
			if ((bad_ev || lost_ev) && !lk.ref_edge) begin
				good_q   <= '0;
				locked_q <= 1'b0;
			end else if (bad_ev) begin
				good_q   <= '0;
				locked_q <= 1'b0;
			end else if (good_ev && good_q == LAST_GOOD) begin
				locked_q <= 1'b1;
			end else if (good_ev) begin
				good_q   <= good_q + synth_cfg_pkg::GOOD_W'(1);
			end
		end
	end

	assign lk.locked   = locked_q;
	assign lk.ref_lost = lost_q;
	assign lk.good_cnt = good_q;

	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (sys_rst_in);

	AST_LOCK_AFTER_RUN: assert property (
		$rose(locked_q) |-> $past(good_q) == LAST_GOOD && $past(good_ev))
		else $error("lock rose without a full run of good cycles");

	AST_BAD_UNLOCKS: assert property (
		ce_in && bad_ev |=> !locked_q && good_q == '0)
		else $error("out of window cycle left lock or count standing");

	AST_HOLD_LOCK: assert property (
		ce_in && locked_q && !bad_ev && !lost_ev |=> locked_q)
		else $error("lock dropped without a bad cycle");

	AST_REF_STOP: assert property (
		ce_in && lost_ev |=> !locked_q && lost_q)
		else $error("quiet reference did not report unlock");

	AST_RESTART: assert property (
		ce_in && good_ev && !locked_q && good_q != LAST_GOOD
		|=> good_q == $past(good_q) + synth_cfg_pkg::GOOD_W'(1))
		else $error("good cycle did not advance the run count");
endmodule : lock_detect

// ===== hdl/synth_ctrl.sv
// holds the digital configuration side of the synthesizer and its lock pin
// assumes an Avalon-MM master with waitrequest and synchronous edge inputs
`timescale 1ns/10ps
module synth_ctrl #(
	parameter int          REF_TIMEOUT  = 1024,
	parameter int          CNT_W        = 8,
	parameter int          N_W          = 16,
	parameter logic [15:0] INT_N_LIMIT  = 16'hffff,
	parameter logic [15:0] FRAC_N_LIMIT = 16'h0fff
) (
	// clock, reset, enable
	input  wire logic                  core_clk_in,
	input  wire logic                  sys_rst_in,
	input  wire logic                  ce_in,
	// register bus
	input  wire logic [3:0]            avs_address_in,
	input  wire logic                  avs_read_in,
	input  wire logic                  avs_write_in,
	input  wire logic [31:0]           avs_writedata_in,
	input  wire logic [3:0]            avs_byteenable_in,
	output logic      [31:0]           avs_readdata_out,
	output logic                       avs_waitrequest_out,
	// divider and detector inputs
	input  wire logic                  reference_input_in,
	input  wire logic                  ref_div_edge_in,
	input  wire logic                  fb_div_edge_in,
	input  wire logic                  pfd_up_in,
	input  wire logic                  pfd_down_in,
	input  wire logic                  analog_lock_in,
	// analog and modulator controls
	output logic                       pump_polarity_sel_out,
	output logic                       pump_high_z_en_out,
	output logic                       ref_doubler_en_out,
	output logic      [2:0]            mod_order_out,
	output logic                       mod_enable_out,
	output logic                       compensation_en_out,
	output logic      [1:0]            dither_strength_sel_out,
	output logic      [21:0]           frac_num_out,
	output logic      [21:0]           frac_den_out,
	output logic      [N_W-1:0]        n_count_limit_out,
	// lock indication
	output logic                       lock_out,
	output logic                       test_lock_out_pin_out,
	output logic                       test_lock_out_pin_oe_n_out
);
	logic [31:0] cfg_q, num_q, den_q, rdata_q;
	logic        wait_q, ref_in_q, fb_half_q, ref_half_q;
	logic        pol_q, hz_q, dbl_q, mod_en_q, comp_q, lock_q;
	logic        pin_q, pin_oe_n_q, pin_d, pin_oe_n_d;
	logic [2:0]  order_q;
	logic [1:0]  dither_strength_sel_q;
	logic [21:0] fnum_q, fden_q;
	logic [N_W-1:0] nlim_q;
	logic [31:0] be_mask;

	lock_if #(.CNT_W(CNT_W)) lk ();

	lock_detect #(
		.CNT_W   (CNT_W),
		.LOCK_N  (synth_cfg_pkg::LOCK_CYCLES),
		.TIMEOUT (REF_TIMEOUT)
	) u_det (
		.core_clk_in (core_clk_in),
		.sys_rst_in  (sys_rst_in),
		.ce_in       (ce_in),
		.lk          (lk.det)
	);

	// bus decode: one wait cycle, then the access completes
	wire logic req      = avs_read_in | avs_write_in;
	wire logic done     = req & ~wait_q;
	wire logic wr_done  = done & avs_write_in;
	wire logic sel_cfg  = avs_address_in == synth_cfg_pkg::OFS_CONFIG;
	wire logic sel_num  = avs_address_in == synth_cfg_pkg::OFS_FRAC_NUM;
	wire logic sel_den  = avs_address_in == synth_cfg_pkg::OFS_FRAC_DEN;
	wire logic sel_stat = avs_address_in == synth_cfg_pkg::OFS_STATUS;

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_be
			assign be_mask[gi*8 +: 8] = {8{avs_byteenable_in[gi]}};
		end
	endgenerate

	wire logic [31:0] wmerge_cfg = (cfg_q & ~be_mask)
		| (avs_writedata_in & be_mask);
	wire logic [31:0] wmerge_num = (num_q & ~be_mask)
		| (avs_writedata_in & be_mask);
	wire logic [31:0] wmerge_den = (den_q & ~be_mask)
		| (avs_writedata_in & be_mask);
	wire logic [31:0] frac_keep = {10'h000, {synth_cfg_pkg::FRAC_W{1'b1}}};

	// configuration fields
	wire logic [2:0] order_f = cfg_q[synth_cfg_pkg::POS_ORDER +: 3];
	wire logic [1:0] dither_strength_sel_f  = cfg_q[synth_cfg_pkg::POS_DITHER +: 2];
	wire logic [2:0] win_f   = cfg_q[synth_cfg_pkg::POS_WINDOW +: 3];
	wire logic [3:0] sel_f   = cfg_q[synth_cfg_pkg::POS_TEST_SEL +: 4];
	wire logic       wide_f  = cfg_q[synth_cfg_pkg::POS_WIDE];
	wire logic       dbl_f   = cfg_q[synth_cfg_pkg::POS_DOUBLER];

	// illegal orders fall back to integer mode so no modulator runs wild
	wire logic       order_bad = order_f > synth_cfg_pkg::ORDER_MAX;
	wire logic [2:0] order_eff = order_bad ?
		synth_cfg_pkg::ORDER_INTEGER : order_f;
	wire logic       low_order = order_eff <= synth_cfg_pkg::ORDER_FIRST;
	wire logic [1:0] dither_strength_sel_eff  = low_order ?
		synth_cfg_pkg::DITHER_OFF : dither_strength_sel_f;
	wire logic       win_bad   = win_f > synth_cfg_pkg::WIN_MAX_CODE;
	wire logic [2:0] win_eff   = win_bad ? synth_cfg_pkg::WIN_MAX_CODE : win_f;

	wire logic [21:0] num_eff = wide_f ? num_q[21:0]
		: (num_q[21:0] & synth_cfg_pkg::NARROW_MASK);
	wire logic [21:0] den_eff = wide_f ? den_q[21:0]
		: (den_q[21:0] & synth_cfg_pkg::NARROW_MASK);

	// detector edges; doubling uses both transitions of the reference
	wire logic ref_toggle = reference_input_in ^ ref_in_q;
	assign lk.ref_edge = dbl_f ? ref_toggle : ref_div_edge_in;
	assign lk.fb_edge  = fb_div_edge_in;
	assign lk.window   =
		CNT_W'(synth_cfg_pkg::win_cycles(win_eff));

	wire logic [31:0] status = {
		25'h0000000,
		lk.good_cnt,
		win_bad,
		order_bad,
		lk.ref_lost,
		lk.locked
	};
	wire logic [31:0] rmux = sel_cfg  ? cfg_q :
	                         sel_num  ? num_q :
	                         sel_den  ? den_q :
	                         sel_stat ? status : 32'h0000_0000;

	// test pin selection; the enable is low while the pin is driven
	always_comb begin
		pin_d      = 1'b0;
		pin_oe_n_d = 1'b0;
		case (sel_f)
			synth_cfg_pkg::TP_HIGH:      pin_d = 1'b1;
			synth_cfg_pkg::TP_LOW:       pin_d = 1'b0;
			synth_cfg_pkg::TP_LOCK:      pin_d = lk.locked;
			synth_cfg_pkg::TP_LOCK_INV:  pin_d = ~lk.locked;
			synth_cfg_pkg::TP_LOCK_OD:   pin_oe_n_d = lk.locked;
			synth_cfg_pkg::TP_ALOCK_OD:  pin_oe_n_d = analog_lock_in;
			synth_cfg_pkg::TP_ALOCK:     pin_d = analog_lock_in;
			synth_cfg_pkg::TP_FB:        pin_d = fb_div_edge_in;
			synth_cfg_pkg::TP_FB_HALF:   pin_d = fb_half_q;
			synth_cfg_pkg::TP_REF:       pin_d = lk.ref_edge;
			synth_cfg_pkg::TP_REF_HALF:  pin_d = ref_half_q;
			synth_cfg_pkg::TP_PFD_UP:    pin_d = pfd_up_in;
			synth_cfg_pkg::TP_PFD_DOWN:  pin_d = pfd_down_in;
			default:                     pin_oe_n_d = 1'b1;
		endcase
	end

	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			wait_q  <= 1'b1;
			rdata_q <= 32'h0000_0000;
		end else if (ce_in) begin
			wait_q <= ~(req & wait_q);
			if (req && wait_q) begin
				rdata_q <= avs_read_in ? rmux : 32'h0000_0000;
			end
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			cfg_q <= synth_cfg_pkg::CONFIG_RESET;
			num_q <= 32'h0000_0000;
			den_q <= 32'h0000_0000;
		end else if (ce_in && wr_done) begin
			if (sel_cfg) cfg_q <= wmerge_cfg & synth_cfg_pkg::CONFIG_MASK;
			if (sel_num) num_q <= wmerge_num & frac_keep;
			if (sel_den) den_q <= wmerge_den & frac_keep;
		end
	end

	// diagnostic halves give a square wave instead of narrow pulses
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			ref_in_q   <= 1'b0;
			fb_half_q  <= 1'b0;
			ref_half_q <= 1'b0;
		end else if (ce_in) begin
			ref_in_q   <= reference_input_in;
			fb_half_q  <= fb_half_q ^ fb_div_edge_in;
			ref_half_q <= ref_half_q ^ lk.ref_edge;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			pol_q      <= 1'b0;
			hz_q       <= 1'b0;
			dbl_q      <= 1'b0;
			order_q    <= synth_cfg_pkg::ORDER_INTEGER;
			mod_en_q   <= 1'b0;
			comp_q     <= 1'b0;
			dither_strength_sel_q     <= synth_cfg_pkg::DITHER_OFF;
			fnum_q     <= 22'h000000;
			fden_q     <= 22'h000000;
			nlim_q     <= N_W'(INT_N_LIMIT);
			lock_q     <= 1'b0;
			pin_q      <= 1'b0;
			pin_oe_n_q <= 1'b1;
		end else if (ce_in) begin
			pol_q      <= cfg_q[synth_cfg_pkg::POS_POLARITY];
			hz_q       <= cfg_q[synth_cfg_pkg::POS_HIGH_Z];
			dbl_q      <= dbl_f;
			order_q    <= order_eff;
			mod_en_q   <= order_eff != synth_cfg_pkg::ORDER_INTEGER;
			comp_q     <= ~low_order;
			dither_strength_sel_q     <= dither_strength_sel_eff;
			fnum_q     <= num_eff;
			fden_q     <= den_eff;
			nlim_q     <= (order_eff == synth_cfg_pkg::ORDER_INTEGER) ?
				N_W'(INT_N_LIMIT) : N_W'(FRAC_N_LIMIT);
			lock_q     <= lk.locked;
			pin_q      <= pin_d;
			pin_oe_n_q <= pin_oe_n_d;
		end
	end

	assign avs_readdata_out           = rdata_q;
	assign avs_waitrequest_out        = wait_q;
	assign pump_polarity_sel_out      = pol_q;
	assign pump_high_z_en_out         = hz_q;
	assign ref_doubler_en_out         = dbl_q;
	assign mod_order_out              = order_q;
	assign mod_enable_out             = mod_en_q;
	assign compensation_en_out        = comp_q;
	assign dither_strength_sel_out    = dither_strength_sel_q;
	assign frac_num_out               = fnum_q;
	assign frac_den_out               = fden_q;
	assign n_count_limit_out          = nlim_q;
	assign lock_out                   = lock_q;
	assign test_lock_out_pin_out      = pin_q;
	assign test_lock_out_pin_oe_n_out = pin_oe_n_q;

	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (sys_rst_in);

	sequence cfg_write_s;
		ce_in && wr_done && sel_cfg && avs_byteenable_in[0];
	endsequence

	AST_POLARITY: assert property (
		cfg_write_s ##1 ce_in ##1 ce_in |->
		pump_polarity_sel_out == $past(avs_writedata_in[0], 2)
		&& pump_high_z_en_out == $past(avs_writedata_in[3], 2))
		else $error("pump controls do not follow the written bits");

	AST_DOUBLER: assert property (
		dbl_f && $past(ce_in) && !$past(sys_rst_in) |->
		lk.ref_edge == (reference_input_in != $past(reference_input_in)))
		else $error("doubled reference edge not fed to the detector");

	AST_NARROW: assert property (
		ce_in && !wide_f |=> frac_num_out[21:10] == 12'h000
		&& frac_den_out[21:10] == 12'h000)
		else $error("narrow fraction mode passed upper bits");

	AST_ORDER_LEGAL: assert property (
		ce_in && order_bad |=> mod_order_out == synth_cfg_pkg::ORDER_INTEGER
		&& !mod_enable_out)
		else $error("illegal order reached the modulator");

	AST_LOW_ORDER_CLEAN: assert property (
		ce_in && low_order |=> !compensation_en_out
		&& dither_strength_sel_out == synth_cfg_pkg::DITHER_OFF)
		else $error("low order mode got dither or compensation");

	AST_INT_RANGE: assert property (
		ce_in && order_eff == synth_cfg_pkg::ORDER_INTEGER
		|=> n_count_limit_out == N_W'(INT_N_LIMIT))
		else $error("integer mode lacks the larger divider range");

	AST_LOCK_PIN: assert property (
		ce_in && sel_f == synth_cfg_pkg::TP_LOCK |=>
		test_lock_out_pin_out == $past(lk.locked)
		&& !test_lock_out_pin_oe_n_out)
		else $error("test pin does not show the lock state");

	sequence bus_wait_s;
		ce_in && req && avs_waitrequest_out;
	endsequence

	sequence bus_answer_s;
		!ce_in || !avs_waitrequest_out;
	endsequence

	AST_BUS_ANSWER: assert property (
		bus_wait_s |=> bus_answer_s)
		else $error("bus access not answered after one wait cycle");

	AST_BUS_IDLE: assert property (
		ce_in && !req |=> avs_waitrequest_out)
		else $error("idle bus did not show waitrequest");

	AST_WIDE: assert property (
		ce_in && wide_f |=> frac_num_out == $past(num_q[21:0])
		&& frac_den_out == $past(den_q[21:0]))
		else $error("wide fraction mode dropped fraction bits");

	AST_DITHER_PASS: assert property (
		ce_in && !low_order |=> dither_strength_sel_out == $past(dither_strength_sel_f))
		else $error("dither code not passed to the modulator");

	AST_HIGH_Z: assert property (
		ce_in |=> pump_high_z_en_out
		== $past(cfg_q[synth_cfg_pkg::POS_HIGH_Z]))
		else $error("pump high impedance does not follow its bit");

	AST_FRAC_RANGE: assert property (
		ce_in && order_eff != synth_cfg_pkg::ORDER_INTEGER
		|=> n_count_limit_out == N_W'(FRAC_N_LIMIT))
		else $error("fractional mode kept the integer divider range");

	AST_LOCK_OUT: assert property (
		ce_in |=> lock_out == $past(lk.locked))
		else $error("lock output does not follow the detector");
endmodule : synth_ctrl

// ===== dv/div_edge_model.sv
// divider edge source standing in for the reference and feedback dividers
// assumes one core clock; skew is the feedback lag in clock cycles
`timescale 1ns/10ps
module div_edge_model (
	// control
	input  wire logic       clk_in,
	input  wire logic       run_in,
	input  wire logic [1:0] skew_in,
	// divider edges and reference level
	output logic            ref_out = 1'b0,
	output logic            fb_out = 1'b0,
	output logic            osc_out = 1'b0
);
	logic [2:0] ph_q = 3'h0;

	// period of 8 cycles keeps the compare rate far below its ceiling
	always_ff @(posedge clk_in) begin
		ph_q <= run_in ? ph_q + 3'h1 : 3'h0;
		osc_out <= run_in & ~osc_out;
		ref_out <= run_in && ph_q == 3'h0;
		fb_out <= run_in && ph_q == {1'b0, skew_in};
	end
endmodule : div_edge_model

// ===== dv/synth_ctrl_test.sv
// self-checking bench: bus tasks, behavioural model, lock detector runs
// assumes div_edge_model drives the divider edges and reference level
`timescale 1ns/10ps
module synth_ctrl_test;
	// inputs
	logic        core_clk_in = 1'b0;
	logic        sys_rst_in = 1'b1;
	logic        ce_in = 1'b1;
	logic [3:0]  avs_address_in = 4'h0;
	logic        avs_read_in = 1'b0;
	logic        avs_write_in = 1'b0;
	logic [31:0] avs_writedata_in = 32'h0;
	logic [3:0]  avs_byteenable_in = 4'hf;
	logic        pfd_up_in = 1'b0;
	logic        pfd_down_in = 1'b0;
	logic        analog_lock_in = 1'b0;
	logic        reference_input_in, ref_div_edge_in, fb_div_edge_in;
	logic        run = 1'b0;
	logic [1:0]  skew = 2'h0;
	// outputs
	logic [31:0] avs_readdata_out;
	logic [21:0] frac_num_out, frac_den_out;
	logic [15:0] n_count_limit_out;
	logic [2:0]  mod_order_out;
	logic [1:0]  dither_strength_sel_out;
	logic        avs_waitrequest_out, pump_polarity_sel_out;
	logic        pump_high_z_en_out, ref_doubler_en_out, mod_enable_out;
	logic        compensation_en_out, lock_out, test_lock_out_pin_out;
	logic        test_lock_out_pin_oe_n_out;
	int          n_errors = 0;
	int          compares = 0;
	logic [15:0] rnd = 16'h728b;
	logic [31:0] rd;

	always #4 core_clk_in = ~core_clk_in;

	synth_ctrl #(.REF_TIMEOUT(16)) synth_ctrl_i (.*);
	div_edge_model div_edge_model_i (.clk_in(core_clk_in), .run_in(run),
		.skew_in(skew), .ref_out(ref_div_edge_in), .fb_out(fb_div_edge_in),
		.osc_out(reference_input_in));

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr

	// {oe_n, level} of the test pin while edges and halves stay idle
	function automatic logic [1:0] pin_model(input logic [3:0] s,
		input logic lk, input logic al, input logic up, input logic dn);
		case (s)
			4'h0, 4'he, 4'hf: return 2'h2;
			4'h1: return 2'h1;
			4'h3: return {1'b0, lk};
			4'h4: return {1'b0, ~lk};
			4'h5: return {lk, 1'b0};
			4'h6: return {al, 1'b0};
			4'h7: return {1'b0, al};
			4'hc: return {1'b0, up};
			4'hd: return {1'b0, dn};
			default: return 2'h0;
		endcase
	endfunction : pin_model

	task automatic print_verdict;
		$display("compares %0d n_errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : print_verdict

	task automatic chk(input string nm, input logic [31:0] e, g);
		compares++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] %s exp %h got %h", nm, e, g);
		end
	endtask : chk

	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int i;
		@(posedge core_clk_in);
		avs_address_in <= a;
		avs_writedata_in <= d;
		avs_write_in <= w;
		avs_read_in <= ~w;
		for (i = 0; avs_waitrequest_out !== 1'b0; i++) begin
			if (i > 20) begin
				n_errors++;
				print_verdict();
			end
			@(posedge core_clk_in);
		end
		rd = avs_readdata_out;
		avs_write_in <= 1'b0;
		avs_read_in <= 1'b0;
	endtask : bus

	task automatic wait_lock(input logic v, input int n);
		int i;
		for (i = 0; lock_out !== v; i++) begin
			if (i >= n) begin
				n_errors++;
				print_verdict();
			end
			@(posedge core_clk_in);
		end
	endtask : wait_lock

	initial begin : main
		int o;
		int e;
		logic [1:0] dt;
		logic [21:0] num;
		logic [21:0] den;
		logic [15:0] r2;
		logic [31:0] cfg;
		logic [1:0]  pin;
		repeat (16) @(posedge core_clk_in);
		sys_rst_in <= 1'b0;
		bus(1'b0, 4'h0, 32'h0);
		chk("config", 32'h304, rd);
		chk("dither", 3, dither_strength_sel_out);
		$display("reset test done");
		// illegal orders 5..7 are written on purpose, expected as integer
		for (o = 0; o < 8; o++) begin
			rnd = lfsr(rnd);
			r2 = lfsr(rnd);
			num = {rnd[5:0], r2};
			den = {num[10:0], num[21:11]};
			dt = (o <= 1 || num == 22'h0) ? 2'h3 : rnd[9:8];
			cfg = {12'h0, r2[15:12], 1'b0, rnd[14:12], 2'h0, dt, 1'b0, o[2:0],
				rnd[3:0]};
			analog_lock_in <= rnd[10];
			pfd_up_in <= rnd[11];
			pfd_down_in <= rnd[15];
			// no frequency shift keying here, so either fraction width is legal
			bus(1'b1, 4'h0, cfg);
			bus(1'b1, 4'h4, {10'h0, num});
			bus(1'b1, 4'h8, {10'h0, den});
			bus(1'b0, 4'hc, 32'h0);
			chk("order flag", o > 4, rd[2]);
			chk("window flag", rnd[14:12] > 3'h5, rd[3]);
			repeat (2) @(posedge core_clk_in);
			e = o > 4 ? 0 : o;
			chk("order", e, mod_order_out);
			chk("mod enable", e != 0, mod_enable_out);
			chk("compensation", e >= 2, compensation_en_out);
			chk("dither", e <= 1 ? 3 : dt, dither_strength_sel_out);
			chk("n limit", e == 0 ? 'hffff : 'hfff, n_count_limit_out);
			chk("polarity", rnd[0], pump_polarity_sel_out);
			chk("doubler", rnd[1], ref_doubler_en_out);
			chk("numerator", rnd[2] ? num : num & 22'h3ff, frac_num_out);
			chk("high z", rnd[3], pump_high_z_en_out);
			chk("den", rnd[2] ? den : den & 22'h3ff, frac_den_out);
			e = pin_model(r2[15:12], 1'b0, rnd[10], rnd[11], rnd[15]);
			pin = {test_lock_out_pin_oe_n_out, test_lock_out_pin_out};
			chk("pin mode", e, pin);
		end
		$display("config test done");
		bus(1'b1, 4'h0, 32'h0003_0304);
		run <= 1'b1;
		repeat (24) @(posedge core_clk_in);
		chk("early lock", 0, lock_out);
		wait_lock(1'b1, 40);
		chk("lock", 1, lock_out);
		@(posedge core_clk_in);
		chk("pin", 1, test_lock_out_pin_out);
		chk("pin oe", 0, test_lock_out_pin_oe_n_out);
		skew <= 2'h1;
		wait_lock(1'b0, 12);
		chk("unlock", 0, lock_out);
		@(posedge core_clk_in);
		chk("pin low", 0, test_lock_out_pin_out);
		skew <= 2'h0;
		repeat (24) @(posedge core_clk_in);
		skew <= 2'h1;
		repeat (8) @(posedge core_clk_in);
		skew <= 2'h0;
		repeat (24) @(posedge core_clk_in);
		chk("restart", 0, lock_out);
		wait_lock(1'b1, 40);
		run <= 1'b0;
		wait_lock(1'b0, 40);
		chk("stopped", 0, lock_out);
		bus(1'b0, 4'hc, 32'h0);
		chk("status", 2'h2, rd[1:0]);
		$display("lock test done");
		print_verdict();
	end
endmodule : synth_ctrl_test
